//--- verilog/ifpc_core.sv
// ifpc_core.sv: phase generator, fetch/execute pipeline, program counter
// assumes: program memory answers combinationally from prog_addr;
// execute requests held stable through T4 of each instruction cycle
//
// The address map and strobed register access are this design's own decisions.
`include "ifpc_cfg.svh"
module ifpc_core (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // register port
  input  wire logic [`IFPC_ADDR_W-1:0]  reg_addr,
  input  wire logic [`IFPC_ALU_W-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [`IFPC_ALU_W-1:0]   reg_rdata,
  // program memory
  output logic      [`IFPC_PC_W-1:0]    prog_addr,
  input  wire logic [`IFPC_INSN_W-1:0]  prog_data,
  // execute stage
  input  wire ifpc_pkg::ifpc_exec_type  exec_req,
  output logic      [`IFPC_INSN_W-1:0]  exec_insn,
  output logic                          exec_valid,
  output logic      [3:0]               phase
);
  //**************************************************
  // state
  //**************************************************
  typedef struct packed {
    ifpc_pkg::ifpc_phase_type                       ph;
    logic [`IFPC_PC_W-1:0]                          pc;
    logic [`IFPC_INSN_W-1:0]                        ir;
    logic [`IFPC_INSN_W-1:0]                        pf;
    logic                                           irv;
    logic                                           dummy;
    logic [`IFPC_ALU_W-1:0]                         acc;
    logic                                           zf;
    logic                                           cf;
    logic [`IFPC_SP_W-1:0]                          sp;
    logic [`IFPC_STACK_DEPTH-1:0][`IFPC_PC_W-1:0]   stk;
    logic                                           pcl_pend;
    logic [`IFPC_ALU_W-1:0]                         pcl_val;
    logic [`IFPC_ALU_W-1:0]                         rdata;
  } ifpc_state_type;

  ifpc_state_type st_ff;
  ifpc_state_type nxt_st;
  ifpc_pkg::ifpc_alu_type alu_y;

  function automatic logic [`IFPC_PC_W-1:0] pc_inc(
      input logic [`IFPC_PC_W-1:0] p);
    // an explicit compare returns the top address to the reset vector, zero
    pc_inc = (p == `IFPC_PC_MAX) ? `IFPC_RESET_VEC : p + 10'h001;
  endfunction

  function automatic logic [`IFPC_PC_W-1:0] page_jump(
      input logic [`IFPC_PC_W-1:0] p,
      input logic [`IFPC_ALU_W-1:0] lo);
    page_jump = {p[`IFPC_PC_W-1:`IFPC_PAGE_LSB], lo};
  endfunction

  ifpc_alu u_alu (
    .a  (st_ff.acc),
    .b  (exec_req.alu_b),
    .op (exec_req.alu_op),
    .y  (alu_y)
  );

  //**************************************************
  // next state
  //**************************************************
  always_comb begin
    logic redirect;
    logic [`IFPC_PC_W-1:0] dest;
    redirect = 1'b0;
    dest     = st_ff.pc;
    nxt_st   = st_ff;
    // phases rotate one per clock
    case (st_ff.ph)
      ifpc_pkg::PH_T1: nxt_st.ph = ifpc_pkg::PH_T2;
      ifpc_pkg::PH_T2: nxt_st.ph = ifpc_pkg::PH_T3;
      ifpc_pkg::PH_T3: nxt_st.ph = ifpc_pkg::PH_T4;
      ifpc_pkg::PH_T4: nxt_st.ph = ifpc_pkg::PH_T1;
      default:         nxt_st.ph = ifpc_pkg::PH_T1;
    endcase
    // software access; a low byte write is latched until cycle end
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `IFPC_PCL_OFS) begin
        nxt_st.rdata = st_ff.pc[`IFPC_ALU_W-1:0];
      end else if (reg_addr == `IFPC_PCH_OFS) begin
        nxt_st.rdata = {6'h00, st_ff.pc[`IFPC_PC_W-1:`IFPC_PAGE_LSB]};
      end else if (reg_addr == `IFPC_STAT_OFS) begin
        nxt_st.rdata = {3'h0, st_ff.dummy, st_ff.irv, 1'b0,
                        st_ff.cf, st_ff.zf};
      end else if (reg_addr == `IFPC_ACC_OFS) begin
        nxt_st.rdata = st_ff.acc;
      end
    end
    if (reg_wr && reg_addr == `IFPC_PCL_OFS) begin
      nxt_st.pcl_pend = 1'b1;
      nxt_st.pcl_val  = reg_wdata;
    end else if (reg_wr && reg_addr == `IFPC_ACC_OFS) begin
      nxt_st.acc = reg_wdata;
    end
    // execute in T4 of the cycle after fetch; alu result held to end
    if (st_ff.ph == ifpc_pkg::PH_T4 && st_ff.irv && !st_ff.dummy) begin
      if (exec_req.alu_en) begin
        nxt_st.acc = alu_y.res;
        nxt_st.zf  = alu_y.zero;
        nxt_st.cf  = alu_y.carry;
      end
      if (exec_req.jump) begin
        redirect = 1'b1;
        dest     = exec_req.target;
      end else if (exec_req.call || exec_req.intr) begin
        redirect = 1'b1;
        dest     = exec_req.target;
        // overflow past six levels overwrites the deepest entry
        // pc already sits past the prefetch, so the return word is pc-1
        if (st_ff.sp < 3'(`IFPC_STACK_DEPTH)) begin
          nxt_st.stk[st_ff.sp] = st_ff.pc - 10'h001;
          nxt_st.sp = st_ff.sp + 3'h1;
        end else begin
          nxt_st.stk[`IFPC_STACK_DEPTH-1] = st_ff.pc - 10'h001;
        end
      end else if (exec_req.ret) begin
        redirect = 1'b1;
        if (st_ff.sp != 3'h0) begin
          dest      = st_ff.stk[st_ff.sp - 3'h1];
          nxt_st.sp = st_ff.sp - 3'h1;
        end
      end else if (exec_req.skip) begin
        redirect = 1'b1;
        dest     = st_ff.pc;
      end
    end
    // a low byte write in the same cycle as a branch loses to it
    if (st_ff.ph == ifpc_pkg::PH_T4 && !redirect
        && (st_ff.pcl_pend || (reg_wr && reg_addr == `IFPC_PCL_OFS))) begin
      redirect = 1'b1;
      dest     = page_jump(st_ff.pc, st_ff.pcl_pend ? st_ff.pcl_val
                                                    : reg_wdata);
    end
    if (st_ff.ph == ifpc_pkg::PH_T4) begin
      nxt_st.pcl_pend = 1'b0;
      if (redirect) begin
        // prefetched word is dropped; next cycle is a dummy
        nxt_st.pc    = dest;
        nxt_st.dummy = 1'b1;
        nxt_st.irv   = 1'b0;
      end else begin
        nxt_st.dummy = 1'b0;
      end
    end
    // T1: latch word at pc and advance; it executes next cycle
    if (st_ff.ph == ifpc_pkg::PH_T1) begin
      nxt_st.ir  = st_ff.pf;
      nxt_st.pf  = prog_data;
      nxt_st.irv = 1'b1;
      nxt_st.pc  = pc_inc(st_ff.pc);
    end
    if (!rst_n) begin
      nxt_st       = '0;
      nxt_st.ph    = ifpc_pkg::PH_T1;
      nxt_st.pc    = `IFPC_RESET_VEC;
      nxt_st.dummy = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  //**************************************************
  // outputs
  //**************************************************
  // execute view is only valid in T2..T4; dummy cycles show invalid
  always_comb begin
    reg_rdata  = st_ff.rdata;
    prog_addr  = st_ff.pc;
    exec_insn  = st_ff.ir;
    exec_valid = st_ff.irv && !st_ff.dummy
                 && st_ff.ph != ifpc_pkg::PH_T1;
    phase      = st_ff.ph;
  end

  //**************************************************
  // checks
  //**************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_t4_redirect;
    st_ff.ph == ifpc_pkg::PH_T4 && st_ff.irv && !st_ff.dummy
      && exec_req.jump;
  endsequence

  AST_PHASE_ROT: assert property (
    st_ff.ph == ifpc_pkg::PH_T1 |=> st_ff.ph == ifpc_pkg::PH_T2
      ##1 st_ff.ph == ifpc_pkg::PH_T3 ##1 st_ff.ph == ifpc_pkg::PH_T4
      ##1 st_ff.ph == ifpc_pkg::PH_T1)
    else $error("phase sequence broken");
  AST_PC_INC: assert property (
    st_ff.ph == ifpc_pkg::PH_T1 |=> st_ff.pc == pc_inc($past(st_ff.pc)))
    else $error("pc not advanced in first phase");
  AST_EXEC_PH: assert property (
    exec_valid |-> st_ff.ph != ifpc_pkg::PH_T1)
    else $error("execute valid in fetch phase");
  AST_JUMP_LOAD: assert property (
    s_t4_redirect |=> st_ff.pc == $past(exec_req.target) && st_ff.dummy)
    else $error("jump target not loaded");
  AST_DUMMY_LEN: assert property (
    s_t4_redirect |=> !exec_valid [*4] ##1 st_ff.ph == ifpc_pkg::PH_T1)
    else $error("branch dummy cycle wrong");
  AST_PCL_PAGE: assert property (
    st_ff.ph == ifpc_pkg::PH_T4 && st_ff.pcl_pend
      && !(exec_valid && (exec_req.jump || exec_req.call || exec_req.intr
           || exec_req.ret || exec_req.skip))
      |=> st_ff.pc[`IFPC_PC_W-1:`IFPC_PAGE_LSB]
        == $past(st_ff.pc[`IFPC_PC_W-1:`IFPC_PAGE_LSB])
        && st_ff.pc[`IFPC_ALU_W-1:0] == $past(st_ff.pcl_val))
    else $error("low byte jump left page");
  AST_PCL_DUMMY: assert property (
    st_ff.ph == ifpc_pkg::PH_T4 && st_ff.pcl_pend |=> st_ff.dummy)
    else $error("low byte write without dummy");
  AST_PCL_READ: assert property (
    reg_rd && reg_addr == `IFPC_PCL_OFS
      |=> reg_rdata == $past(st_ff.pc[`IFPC_ALU_W-1:0]))
    else $error("low byte read mismatch");
  AST_WRAP: assert property (
    st_ff.ph == ifpc_pkg::PH_T1 && st_ff.pc == `IFPC_PC_MAX
      |=> st_ff.pc == `IFPC_RESET_VEC)
    else $error("pc did not wrap");
endmodule

//--- verilog/ifpc_cfg.svh
// ifpc_cfg.svh: offsets, reset values, field positions and counts
// assumes: included by bare name from the package and the pipeline core
`ifndef IFPC_CFG_SVH
`define IFPC_CFG_SVH
`define IFPC_PC_W        10
`define IFPC_PAGE_LSB    8
`define IFPC_ALU_W       8
`define IFPC_ADDR_W      4
`define IFPC_PCL_OFS     4'h0
`define IFPC_PCH_OFS     4'h1
`define IFPC_STAT_OFS    4'h2
`define IFPC_ACC_OFS     4'h3
`define IFPC_RESET_VEC   10'h000
`define IFPC_PC_MAX      10'h3FF
`define IFPC_STACK_DEPTH 6
`define IFPC_SP_W        3
`define IFPC_INSN_W      15
`endif

//--- verilog/ifpc_pkg.sv
// ifpc_pkg.sv: types shared by the fetch/pc core and its alu
// assumes: ifpc_cfg.svh on the include path
`include "ifpc_cfg.svh"
package ifpc_pkg;
  typedef enum logic [3:0] {
    PH_T1 = 4'b0001,
    PH_T2 = 4'b0010,
    PH_T3 = 4'b0100,
    PH_T4 = 4'b1000
  } ifpc_phase_type;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR  = 3'h3,
    ALU_XOR = 3'h4,
    ALU_RL  = 3'h5,
    ALU_INC = 3'h6,
    ALU_DEC = 3'h7
  } ifpc_aluop_type;

  // one decoded control request from the execute stage
  typedef struct packed {
    logic                     jump;
    logic                     call;
    logic                     intr;
    logic                     ret;
    logic                     skip;
    logic                     alu_en;
    ifpc_aluop_type           alu_op;
    logic [`IFPC_ALU_W-1:0]   alu_b;
    logic [`IFPC_PC_W-1:0]    target;
  } ifpc_exec_type;

  typedef struct packed {
    logic [`IFPC_ALU_W-1:0] res;
    logic                   zero;
    logic                   carry;
  } ifpc_alu_type;
endpackage

//--- verilog/ifpc_alu.sv
// ifpc_alu.sv: 8-bit combinational alu for the execute stage
// assumes: operands stable during the execute phases
`include "ifpc_cfg.svh"
module ifpc_alu (
  // operands
  input  wire logic [`IFPC_ALU_W-1:0] a,
  input  wire logic [`IFPC_ALU_W-1:0] b,
  input  wire ifpc_pkg::ifpc_aluop_type op,
  // result
  output ifpc_pkg::ifpc_alu_type     y
);
  logic [`IFPC_ALU_W:0] wide;

  always_comb begin
    wide = '0;
    case (op)
      ifpc_pkg::ALU_ADD: wide = {1'b0, a} + {1'b0, b};
      ifpc_pkg::ALU_SUB: wide = {1'b0, a} - {1'b0, b};
      ifpc_pkg::ALU_AND: wide = {1'b0, a & b};
      ifpc_pkg::ALU_OR:  wide = {1'b0, a | b};
      ifpc_pkg::ALU_XOR: wide = {1'b0, a ^ b};
      ifpc_pkg::ALU_RL:  wide = {a[7], a[6:0], a[7]};
      ifpc_pkg::ALU_INC: wide = {1'b0, a} + 9'h001;
      ifpc_pkg::ALU_DEC: wide = {1'b0, a} - 9'h001;
      default:           wide = '0;
    endcase
    y.res   = wide[`IFPC_ALU_W-1:0];
    y.carry = wide[`IFPC_ALU_W];
    y.zero  = (wide[`IFPC_ALU_W-1:0] == 8'h00);
  end
endmodule

//--- sim/ifpc_prog_mem.sv
// ifpc_prog_mem.sv: program memory model for the fetch/pc bench
// assumes: read is combinational, every 10-bit address holds a word
module ifpc_prog_mem (
  // fetch address
  input  wire logic [9:0]  addr,
  // instruction word
  output logic      [14:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  // each word carries its own address, so a wrong fetch shows at once
  assign data = {5'h15, addr};
endmodule

//--- sim/ifpc_core_bench.sv
// ifpc_core_bench.sv: self-checking bench for the fetch/pc core
// assumes: ifpc_prog_mem as program memory, 10 MHz clock
`include "ifpc_cfg.svh"
module ifpc_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk, rst_n, reg_wr, reg_rd, exec_valid;
  logic [3:0]              reg_addr, phase;
  logic [7:0]              reg_wdata, reg_rdata, rv;
  logic [9:0]              prog_addr, pc_t4, ret_pc;
  logic [14:0]             prog_data, exec_insn;
  ifpc_pkg::ifpc_exec_type exec_req;
  int                      mismatches, check_count, i;
  logic [7:0]              alu_exp [8] = '{8'h12, 8'h0C, 8'h03, 8'h0F,
                                           8'h0C, 8'h1E, 8'h10, 8'h0E};

  ifpc_core dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prog_addr(prog_addr), .prog_data(prog_data),
    .exec_req(exec_req), .exec_insn(exec_insn), .exec_valid(exec_valid),
    .phase(phase));
  ifpc_prog_mem mem (.addr(prog_addr), .data(prog_data));

  // ********************************
  // tasks
  // ********************************
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // bounded so a stuck phase counter cannot hang the run
  task automatic wait_ph(input logic [3:0] p, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((phase !== p || (v && exec_valid !== 1'b1)) && n < 40);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask
  // request held from T3 through the edge leaving T4
  task automatic issue(input logic [5:0] f, input logic [2:0] op,
                       input logic [7:0] b, input logic [9:0] t);
    wait_ph(ifpc_pkg::PH_T2, 1'b1);
    @(posedge clk);
    exec_req <= ifpc_pkg::ifpc_exec_type'({f, op, b, t});
    wait_ph(ifpc_pkg::PH_T4, 1'b0);
    pc_t4 = exec_insn[9:0] + 10'h001;
    @(posedge clk);
    exec_req <= '0;
    @(negedge clk);
  endtask
  task automatic results();
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ********************************
  // clock, watchdog, tests
  // ********************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    exec_req = '0;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(prog_addr, 10'h000);
    for (i = 0; i < 8; i++) begin
      chk(phase, 4'h1 << (i % 4));
      if (i == 5) begin
        chk(exec_valid, 1'b1);
        chk(exec_insn, {5'h15, 10'h000});
      end
      @(negedge clk);
    end
    chk(prog_addr, 10'h002);
    rd(4'hF);
    chk(rv, 8'h00);
    issue(6'h20, 3'h0, 8'h00, 10'h2A5);
    chk(prog_addr, 10'h2A5);
    @(negedge clk);
    chk(exec_valid, 1'b0);
    wait_ph(ifpc_pkg::PH_T2, 1'b1);
    rd(4'h0);
    chk(rv, prog_addr[7:0]);
    wr(4'h0, 8'h34);
    wait_ph(ifpc_pkg::PH_T1, 1'b0);
    chk(prog_addr, 10'h234);
    @(negedge clk);
    chk(exec_valid, 1'b0);
    rd(4'h1);
    chk(rv, 8'h02);
    issue(6'h02, 3'h0, 8'h00, 10'h000);
    @(negedge clk);
    chk(exec_valid, 1'b0);
    for (i = 0; i < 2; i++) begin
      issue(i[0] ? 6'h08 : 6'h10, 3'h0, 8'h00, {9'h080, i[0]});
      ret_pc = pc_t4;
      chk(prog_addr, {9'h080, i[0]});
      issue(6'h04, 3'h0, 8'h00, 10'h000);
      chk(prog_addr, ret_pc);
    end
    issue(6'h20, 3'h0, 8'h00, 10'h3FF);
    repeat (4) @(negedge clk);
    chk(prog_addr, 10'h000);
    // every alu code once, accumulator reloaded before each
    for (i = 0; i < 8; i++) begin
      wr(4'h3, 8'h0F);
      issue(6'h01, i[2:0], 8'h03, 10'h000);
      rd(4'h3);
      chk(rv, alu_exp[i]);
    end
    results();
  end
endmodule
